// *** design/err_status_defs.svh ***
`ifndef ERR_STATUS_DEFS_SVH
`define ERR_STATUS_DEFS_SVH

// Error source bit positions
`define ESRC_NAN_BIT 1
`define ESRC_INTR_WR_BIT 2
`define ESRC_RANGE_BIT 4
`define ESRC_MISALIGN_BIT 5
`define ESRC_SANITY_BIT 6
`define ESRC_SYNC_BIT 7
// Implemented error source bits
`define ESRC_IMPL_MASK 8'hF6
// Reserved mask bits, always read as one
`define EMASK_RSVD 16'h0D0D
`define EMASK_RESET 16'hFFFF
`define ESRC_RESET 8'h00
// Mask halves
`define EMASK_NOTIFY_LSB 0
`define EMASK_HALT_LSB 8

`endif

// *** design/err_status_pkg.sv ***
package err_status_pkg;
   typedef logic [7:0] err_src_t;
   typedef logic [15:0] err_mask_t;
   typedef enum {SYNC_WAIT, SYNC_RUN} strobe_state_t;
endpackage

// *** design/sync_fall_detect.sv ***
`timescale 1ns/10ps
// Two-stage synchroniser with falling-edge pulse from the second stage on
module sync_fall_detect
   import err_status_pkg::*;
(
   input wire logic mclk_in,
   input wire logic rst_in,
   input wire logic async_in,
   output logic fall_out
);
   logic meta_ff;
   logic stable_ff;
   logic prev_ff;
   strobe_state_t state_ff;
   strobe_state_t nxt_state;
   logic running;

   always_comb begin
      case (state_ff)
         SYNC_WAIT: nxt_state = SYNC_RUN;
         SYNC_RUN: nxt_state = SYNC_RUN;
         default: nxt_state = SYNC_WAIT;
      endcase
   end

   // Waiting one cycle avoids a false edge from the reset value
   assign running = (state_ff == SYNC_RUN);

   always_ff @(posedge mclk_in) begin
      if (rst_in) begin
         meta_ff <= 1'b0;
         stable_ff <= 1'b0;
         prev_ff <= 1'b0;
         state_ff <= SYNC_WAIT;
         fall_out <= 1'b0;
      end else begin
         meta_ff <= async_in;
         stable_ff <= meta_ff;
         prev_ff <= stable_ff;
         state_ff <= nxt_state;
         fall_out <= running & prev_ff & ~stable_ff;
      end
   end
endmodule

// *** design/error_status_and_mask.sv ***
`timescale 1ns/10ps
`include "err_status_defs.svh"

// Functional notes
// R1: An 8-bit error source register is readable by the host only.
// R2: A host read returns the source contents and then clears them.
// R3: Source bits: NaN 1, intr 2, range 4, misalign 5, sanity 6, sync 7.
// R4: Misalign is flagged for float addresses not x4 or integer not x2.
// R5: Sanity lapse is flagged when sanity enable is one and strobe falls.
// R6: A 16-bit error mask register is host readable and writable.
// R7: Mask bits 0, 2, 3, 8, 10, 11 always read as one.
// R8: Low mask bits that are one block notification of the host.
// R9: Mask bit n+8 that is one keeps source bit n from halting.
// R10: Reset sets every mask bit to one.
// R11: Notify and halt follow any set source bit with a zero mask bit.
// R12: Source bits stay set until read; an event during the read wins.
module error_status_and_mask
   import err_status_pkg::*;
#(
   parameter int SRC_W = 8,
   parameter int MASK_W = 16
)
(
   input wire logic mclk_in,
   input wire logic rst_in,
   // Host access, one-cycle strobes on mclk_in
   input wire logic src_rd_in,
   input wire logic mask_rd_in,
   input wire logic mask_wr_in,
   input wire logic [15:0] mask_wdata_in,
   output logic [15:0] rdata_out,
   // Error events, one-cycle pulses from core logic; sanity enable is a level and the strobe a pin
   input wire logic not_a_number_flag_in,
   input wire logic host_intr_reg_written_in,
   input wire logic arith_range_flag_in,
   input wire logic access_valid_in,
   input wire logic access_is_float_in,
   input wire logic [1:0] access_addr_lsb_in,
   input wire logic sanity_enable_in,
   input wire logic sanity_strobe_input_in,
   input wire logic sync_drop_flag_in,
   // Outputs
   output logic host_notify_flag_out,
   output logic halt_req_out,
   output logic [7:0] error_source_out
);
   localparam err_src_t SRC_RST = `ESRC_RESET;
   localparam err_src_t SRC_IMPL = `ESRC_IMPL_MASK;
   localparam err_mask_t MASK_RST = `EMASK_RESET;
   localparam err_mask_t MASK_RSVD = `EMASK_RSVD;

   // The bit map and the two mask halves are fixed by the rules
   if (SRC_W != 8) begin : g_bad_src_w
      $error("SRC_W must be 8 to match the source bit map");
   end
   if (MASK_W != 2 * SRC_W) begin : g_bad_mask_w
      $error("MASK_W must hold one notify and one halt half");
   end
   if (`ESRC_SYNC_BIT >= SRC_W) begin : g_bad_bit_map
      $error("Source bit positions exceed SRC_W");
   end

   // Operand alignment: floats on four bytes, integers on two
   function automatic logic is_misaligned(
      input logic is_float,
      input logic [1:0] addr_lsb
   );
      logic bad;
      bad = is_float ? (addr_lsb != 2'b00) : addr_lsb[0];
      return bad;
   endfunction

   // Set source bits that a mask half lets through
   function automatic err_src_t live_bits(
      input err_src_t src,
      input err_src_t half
   );
      err_src_t hits;
      hits = src & ~half;
      return hits;
   endfunction

   // Source word as the host sees it, upper byte zero
   function automatic err_mask_t src_read_word(
      input err_src_t src
   );
      err_mask_t word;
      word = {{(MASK_W - SRC_W){1'b0}}, src};
      return word;
   endfunction

   err_src_t src_bits;
   err_src_t nxt_src;
   err_src_t events;
   err_src_t clr_bits;
   err_mask_t mask_ff;
   err_mask_t nxt_mask;
   err_mask_t mask_view;
   err_src_t notify_half;
   err_src_t halt_half;
   err_src_t notify_hits;
   err_src_t halt_hits;
   logic strobe_fall;
   logic misaligned;
   logic sanity_lapse;
   logic nan_evt;
   logic intr_evt;
   logic range_evt;
   logic sync_evt;
   logic nxt_notify;
   logic nxt_halt;
   logic rd_any;
   err_mask_t src_word;
   err_mask_t nxt_rdata;

   // Strobe is a pin, so it is synchronised before edge detection
   sync_fall_detect u_sync (
      .mclk_in(mclk_in),
      .rst_in(rst_in),
      .async_in(sanity_strobe_input_in),
      .fall_out(strobe_fall)
   );

   // Core events arrive as one-cycle pulses on this clock
   assign nan_evt = not_a_number_flag_in;
   assign intr_evt = host_intr_reg_written_in;
   assign range_evt = arith_range_flag_in;
   assign sync_evt = sync_drop_flag_in;
   assign misaligned = access_valid_in &
      is_misaligned(access_is_float_in, access_addr_lsb_in); // R4
   // Enable is a level, so it only gates the synchronised edge pulse
   assign sanity_lapse = sanity_enable_in & strobe_fall; // R5

   always_comb begin
      events = SRC_RST;
      events[`ESRC_NAN_BIT] = nan_evt; // R3
      events[`ESRC_INTR_WR_BIT] = intr_evt; // R3
      events[`ESRC_RANGE_BIT] = range_evt; // R3
      events[`ESRC_MISALIGN_BIT] = misaligned; // R3
      events[`ESRC_SANITY_BIT] = sanity_lapse; // R3
      events[`ESRC_SYNC_BIT] = sync_evt; // R3
   end

   // A source read clears every implemented bit at once
   assign clr_bits = src_rd_in ? SRC_IMPL : SRC_RST; // R2

   // One cell per source bit. The set term follows the clear, so an
   // event in the read cycle is kept and reported by the next read.
   for (genvar i = 0; i < SRC_W; i++) begin : g_src
      logic cell_ff;
      assign nxt_src[i] = SRC_IMPL[i]
         & ((cell_ff & ~clr_bits[i]) | events[i]); // R12
      always_ff @(posedge mclk_in) begin
         if (rst_in) begin
            cell_ff <= SRC_RST[i];
         end else begin
            cell_ff <= nxt_src[i]; // R1
         end
      end
      assign src_bits[i] = cell_ff;
   end

   // Mask register; only the host writes it, never the core
   assign nxt_mask = mask_wr_in ? mask_wdata_in : mask_ff; // R6

   always_ff @(posedge mclk_in) begin
      if (rst_in) begin
         mask_ff <= MASK_RST; // R10
      end else begin
         mask_ff <= nxt_mask; // R6
      end
   end

   // Reserved bits forced at the view, so writes to them are harmless
   assign mask_view = mask_ff | MASK_RSVD; // R7
   assign notify_half = mask_view[`EMASK_NOTIFY_LSB +: SRC_W]; // R8
   assign halt_half = mask_view[`EMASK_HALT_LSB +: SRC_W]; // R9

   // Flags look at the next source state, so they settle with it
   assign notify_hits = live_bits(nxt_src, notify_half); // R8
   assign halt_hits = live_bits(nxt_src, halt_half); // R9
   assign nxt_notify = |notify_hits; // R11
   assign nxt_halt = |halt_hits; // R11

   assign src_word = src_read_word(src_bits);
   assign rd_any = src_rd_in | mask_rd_in;
   // Source read wins when both strobes come together
   assign nxt_rdata = src_rd_in ? src_word : mask_view; // R2 R7

   // Read data holds until the next read
   always_ff @(posedge mclk_in) begin
      if (rst_in) begin
         rdata_out <= 16'h0000;
      end else if (rd_any) begin
         rdata_out <= nxt_rdata; // R2
      end
   end

   always_ff @(posedge mclk_in) begin
      if (rst_in) begin
         host_notify_flag_out <= 1'b0;
      end else begin
         host_notify_flag_out <= nxt_notify; // R11
      end
   end

   always_ff @(posedge mclk_in) begin
      if (rst_in) begin
         halt_req_out <= 1'b0;
      end else begin
         halt_req_out <= nxt_halt; // R11
      end
   end

   // Copy of the source register for the core side
   always_ff @(posedge mclk_in) begin
      if (rst_in) begin
         error_source_out <= SRC_RST;
      end else begin
         error_source_out <= nxt_src;
      end
   end
endmodule

// *** verif/err_monitor.sv ***
`timescale 1ns/10ps
module err_monitor(
   input wire logic mclk_in,
   input wire logic rst_in,
   input wire logic src_rd_in,
   input wire logic mask_rd_in,
   input wire logic not_a_number_flag_in,
   input wire logic arith_range_flag_in,
   input wire logic sync_drop_flag_in,
   input wire logic host_notify_flag_out,
   input wire logic halt_req_out,
   input wire logic [15:0] rdata_out,
   input wire logic [7:0] error_source_out
);
   wire [7:0] s = error_source_out;
   wire [15:0] q = rdata_out;
   wire r = src_rd_in;
   wire n = host_notify_flag_out | halt_req_out;
   default clocking @(posedge mclk_in); endclocking
   default disable iff rst_in;
   property p_rsv; mask_rd_in && !r |=> &(q | 16'hF2F2); endproperty
   a_rsv: assert property (p_rsv) else $error("mask rsv");
   property p_hi; r |=> (q & 16'hFF09) == 0; endproperty
   a_hi: assert property (p_hi) else $error("src high");
   property p_rb; r |=> q[7:0] == $past(s); endproperty
   a_rb: assert property (p_rb) else $error("src read");
   property p_clr; r && !arith_range_flag_in |=> !s[4]; endproperty
   a_clr: assert property (p_clr) else $error("clear");
   property p_hold; !r |=> &(s | ~$past(s)); endproperty
   a_hold: assert property (p_hold) else $error("hold");
   property p_nan; not_a_number_flag_in |=> s[1]; endproperty
   a_nan: assert property (p_nan) else $error("nan");
   property p_syn; sync_drop_flag_in |=> s[7]; endproperty
   a_syn: assert property (p_syn) else $error("sync");
   property p_idle; s == 0 |-> !n; endproperty
   a_idle: assert property (p_idle) else $error("flags");
endmodule
bind error_status_and_mask err_monitor mon(.*);

// *** verif/host_model.sv ***
`timescale 1ns/10ps
module host_model(
   input wire logic mclk_in,
   input wire logic [15:0] rdata_in,
   output logic [18:0] bus_out
);
   initial bus_out = 0;
   // Bus is write, mask read, source read, then data
   task acc(input logic [2:0] k, logic [15:0] v, output logic [15:0] d);
      @(posedge mclk_in) bus_out <= {k, v};
      @(posedge mclk_in) bus_out <= {3'h0, ~v};
      #1 d = rdata_in;
   endtask
endmodule

// *** verif/test_error_status_and_mask.sv ***
`timescale 1ns/10ps
module test_error_status_and_mask;
   logic c = 0, rs = 1, en = 0, sy = 1, nf, hr;
   logic [5:0] ev = 0;
   logic [18:0] b;
   logic [15:0] rd, d, m;
   logic [7:0] so;
   int num_errors = 0, checks = 0;
   int bt[$] = '{1, 2, 4, 5, 5, 7};
   int mdl_mask, mdl_src;
   always #20 c = ~c;
   host_model host(.mclk_in(c), .rdata_in(rd), .bus_out(b));
   error_status_and_mask dut(.mclk_in(c), .rst_in(rs), .src_rd_in(b[16]),
      .mask_rd_in(b[17]), .mask_wr_in(b[18]), .mask_wdata_in(b[15:0]),
      .rdata_out(rd), .not_a_number_flag_in(ev[0]),
      .host_intr_reg_written_in(ev[1]), .arith_range_flag_in(ev[2]),
      .access_valid_in(|ev[4:3]), .access_is_float_in(ev[3]),
      .access_addr_lsb_in({ev[3], ev[4]}), .sanity_enable_in(en),
      .sanity_strobe_input_in(sy), .sync_drop_flag_in(ev[5]),
      .host_notify_flag_out(nf), .halt_req_out(hr), .error_source_out(so));
   task chk(input logic [15:0] g, e);
      checks++;
      if (g !== e) begin
         num_errors++;
         $display("wrong value at %0t: %h not %h", $time, g, e);
      end
   endtask
   task report_and_stop;
      $display("errors %0d checks %0d", num_errors, checks);
      if (num_errors == 0 && checks > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   initial begin
      void'($urandom(32'h2CE8DEEC));
      repeat (16) @(posedge c);
      rs <= 0;
      host.acc(3'h2, 0, d);
      chk(d, 16'hFFFF);
      for (int i = 0; i < 6; i++) begin
         m = $urandom;
         host.acc(3'h4, m, d);
         host.acc(3'h2, 0, d);
         mdl_mask = m | 16'h0D0D;
         chk(d, mdl_mask);
         @(posedge c) ev <= 6'h1 << i;
         @(posedge c) ev <= 0;
         mdl_src = 1 << bt[i];
         #1 chk(nf, |(mdl_src & ~mdl_mask[7:0]));
         chk(hr, |(mdl_src & ~mdl_mask[15:8]));
         chk(so, mdl_src);
         host.acc(3'h1, 0, d);
         chk(d, mdl_src);
         mdl_src = 0;
         chk(so, mdl_src);
      end
      // Event lands in the read cycle and must survive the clear
      fork
         host.acc(3'h1, 0, d);
         @(posedge c) ev <= 1;
      join
      @(posedge c) ev <= 0;
      chk(d, 0);
      #1 chk(so, 2);
      @(posedge c) en <= 1;
      @(posedge c) sy <= 0;
      #1 for (int k = 0; k < 9 && so[6] !== 1'b1; k++) #40;
      chk(so[6], 1);
      report_and_stop;
   end
endmodule
